// ===== nfc_framing_cfg.svh
`ifndef NFC_FRAMING_CFG_SVH
`define NFC_FRAMING_CFG_SVH

// ==========================================================================
// Register word indices and offsets (byte addresses; word aligned)
`define RATE_IDX           8'h04
`define TYPEA_IDX          8'h05
`define TYPEB_IDX          8'h06
`define ADDR_RATE          12'h010
`define ADDR_TYPEA         12'h014
`define ADDR_TYPEB         12'h018
`define ADDR_STATUS        12'h01C
// ==========================================================================
// Field positions
`define TX_RATE_MSB        7
`define TX_RATE_LSB        4
`define RX_RATE_MSB        3
`define RX_RATE_LSB        0
`define A_NO_TX_PAR        7
`define A_NO_RX_PAR        6
`define A_WRAP             5
`define A_PLEN_MSB         4
`define A_PLEN_LSB         1
`define A_ANTCL            0
`define B_EGT_MSB          7
`define B_EGT_LSB          5
`define B_SOF_LOW          4
`define B_SOF_HIGH         3
`define B_EOF_LOW          2
`define B_MID              1
`define B_OMIT             0
// ==========================================================================
// Reset values and timing figures
`define RESET_VAL          8'h00
`define PEER_RATE_DEFAULT  8'h00
`define PLEN_BASE_128      6'h23
`define PLEN_BASE_64       6'h12
`define PLEN_BASE_32       6'h09
`define PLEN_BASE_16       6'h05
`define EGT_MAX            3'h6
`define SOF_LOW_SHORT      4'hA
`define SOF_HIGH_SHORT     4'h2
`define EOF_LOW_SHORT      4'hA
`define WRAP_START_BYTE    8'hF0

`endif

// ===== nfc_framing_config_regs.sv
// Summary of operation
// [RULE1] Transmit rate is the upper nibble of rate register: 0..3 give fc/128..fc/16.
// [RULE2] Receive rate is the lower nibble, same coding, when protocol allows differing rates.
// [RULE3] Any undefined rate code disables transmit and receive.
// [RULE4] All three registers clear at reset and on restore-defaults command.
// [RULE5] Enter-standard-peer command loads the rate register automatically.
// [RULE6] Transmit parity suppress sends FIFO stream with no parity; host uses send-unchecked.
// [RULE7] Receive parity suppress stores raw bits unchecked; host keeps it clear outside type A.
// [RULE8] Transport wrap adds F0 and length bytes on transmit, drops F0 on receive.
// [RULE9] Pulse width at fc/128 is 35 plus signed field, 27 to 42 periods.
// [RULE10] Higher rates use bases 18, 9, 5 with limited ranges; fc/64 folds above 0100.
// [RULE11] Host sets anticollision bit when sending a bit-oriented anticollision frame.
// [RULE12] Guard time field gives 0 to 6 units; code 7 gives 6.
// [RULE13] SOF low phase is 10 units, or 11 when bit set.
// [RULE14] SOF high phase is 2 units, or 3 when bit set.
// [RULE15] EOF low phase is 10 units, or 11 when bit set.
// [RULE16] Mid-spec bit overrides SOF/EOF bits with mid-range timings; the code loads the short figures 10, 2, 10 instead.
// [RULE17] Receive start/stop omit: fixed SOF 10 low 2 high, no EOF, last full byte kept.
// [RULE18] For transmit without start/stop bits the host uses stream mode.
// [RULE19] Written settings take effect at next frame start, not mid-frame.
`include "nfc_framing_cfg.svh"
`default_nettype none

module nfc_framing_config_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        restore_defaults_cmd,
  input  wire logic        enter_standard_peer_cmd,
  input  wire logic        rates_may_differ,
  input  wire logic        frame_start,
  input  wire logic        frame_active,
  output logic      [3:0]  tx_rate,
  output logic      [3:0]  rx_rate,
  output logic             txrx_enable,
  output logic             tx_parity_suppress,
  output logic             rx_parity_suppress,
  output logic             transport_frame_wrap,
  output logic      [7:0]  wrap_start_byte,
  output logic      [5:0]  pulse_width,
  output logic             pulse_width_valid,
  output logic             anticoll_frame,
  output logic      [2:0]  guard_etu,
  output logic      [3:0]  sof_low_etu,
  output logic      [3:0]  sof_high_etu,
  output logic      [3:0]  eof_low_etu,
  output logic             eof_required,
  output logic             receive_startstop_omit
);

  // ========================================================================
  // Helpers
  // Only codes 0 to 3 name a defined bit rate
  function automatic logic rate_ok(input logic [3:0] code);
    rate_ok = (code <= 4'(nfc_framing_pkg::RATE_FC16));
  endfunction

  // Pulse width table: returns {valid, width}
  function automatic logic [6:0] plen_map(input logic [3:0] rate, input logic [3:0] f);
    logic signed [5:0] s;
    logic [5:0]        w;
    logic              v;
    // Code read as a signed offset from the base width
    s = 6'(signed'(f));
    w = 6'h00;
    v = 1'b0;
    case (rate)
      // fc/128: every code is valid
      4'(nfc_framing_pkg::RATE_FC128): begin
        w = 6'(`PLEN_BASE_128 + s);
        v = (s >= -6'sd8) && (s <= 6'sd7);
      end
      // fc/64: width rises up to code 4 and falls back above it
      4'(nfc_framing_pkg::RATE_FC64): begin
        if (f[3] == 1'b0 && f[2] == 1'b1) begin
          w = 6'(`PLEN_BASE_64 + 6'd4 - (6'(f) - 6'd4)); // folds above 0100
        end else begin
          w = 6'(`PLEN_BASE_64 + s);
        end
        v = (s >= -6'sd6) && (s <= 6'sd6);
      end
      // fc/32: codes -4 to 4
      4'(nfc_framing_pkg::RATE_FC32): begin
        w = 6'(`PLEN_BASE_32 + s);
        v = (s >= -6'sd4) && (s <= 6'sd4);
      end
      // fc/16: codes -3 to 3
      4'(nfc_framing_pkg::RATE_FC16): begin
        w = 6'(`PLEN_BASE_16 + s);
        v = (s >= -6'sd3) && (s <= 6'sd3);
      end
      // Undefined rate: no usable width
      default: begin
        w = 6'h00;
        v = 1'b0;
      end
    endcase
    plen_map = {v, w};
  endfunction

  // ========================================================================
  // Software-visible registers
  // Stored registers and the registered bus answer
  logic [7:0] rate_reg, rate_next;
  logic [7:0] typea_reg, typea_next;
  logic [7:0] typeb_reg, typeb_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pslverr_reg, pslverr_next;
  logic        pready_reg, pready_next;
  // Frame activity, also visible in the status register
  logic        active_frame_reg;

  // Transfer qualifiers and address decode
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  assign wr_acc   = psel && penable && pwrite && pready_reg;
  assign rd_setup = psel && !penable;
  assign mapped   = (paddr == `ADDR_RATE) || (paddr == `ADDR_TYPEA) ||
                    (paddr == `ADDR_TYPEB) || (paddr == `ADDR_STATUS);

  // Register write, command and read path
  always_comb begin
    rate_next    = rate_reg;
    typea_next   = typea_reg;
    typeb_next   = typeb_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    pready_next  = 1'b0;
    // Setup phase: prepare the answer for the access phase
    if (rd_setup) begin
      pready_next = 1'b1;
      pslverr_next = !mapped;
      case (paddr)
        `ADDR_RATE:   prdata_next = {24'h000000, rate_reg};
        `ADDR_TYPEA:  prdata_next = {24'h000000, typea_reg};
        `ADDR_TYPEB:  prdata_next = {24'h000000, typeb_reg};
        `ADDR_STATUS: prdata_next = {30'h00000000, active_frame_reg, txrx_enable};
        default:      prdata_next = 32'h00000000; // Unmapped reads return zero
      endcase
    end
    // Write lands at the access edge, lane 0 only
    if (wr_acc && pstrb[0]) begin
      case (paddr)
        `ADDR_RATE:  rate_next  = pwdata[7:0];  // [RULE1] [RULE2]
        `ADDR_TYPEA: typea_next = pwdata[7:0];
        `ADDR_TYPEB: typeb_next = pwdata[7:0];
        // Status and unmapped writes are dropped
        default:     rate_next  = rate_reg;
      endcase
    end
    // Commands override a write in the same cycle; restore comes last and wins
    if (enter_standard_peer_cmd) begin
      rate_next = `PEER_RATE_DEFAULT; // [RULE5]
    end
    if (restore_defaults_cmd) begin
      rate_next  = `RESET_VAL; // [RULE4]
      typea_next = `RESET_VAL;
      typeb_next = `RESET_VAL;
    end
  end

  // Register and bus-side state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_reg    <= `RESET_VAL; // [RULE4]
      typea_reg   <= `RESET_VAL;
      typeb_reg   <= `RESET_VAL;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
      pready_reg  <= 1'b0;
    end else begin
      rate_reg    <= rate_next;
      typea_reg   <= typea_next;
      typeb_reg   <= typeb_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg  <= pready_next;
    end
  end

  // Bus answer straight from flops: one wait-free access per setup
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ========================================================================
  // Frame-synchronous snapshot of decoded settings
  logic [7:0]  wsb_reg;
  logic [3:0]  tx_rate_reg, rx_rate_reg;
  logic        txrx_reg, ntp_reg, nrp_reg, wrap_reg, antcl_reg, omit_reg, eofreq_reg;
  logic [5:0]  pw_reg;
  logic        pwv_reg;
  logic [2:0]  egt_reg;
  logic [3:0]  sofl_reg, sofh_reg, eofl_reg;

  // Decoded values waiting for the next snapshot load
  logic [3:0]  txr_d, rxr_d, sofl_d, sofh_d, eofl_d;
  logic [2:0]  egt_d;
  logic [6:0]  pw_d;
  logic        upd;

  // Decode configuration into framing parameters
  always_comb begin
    txr_d = rate_reg[`TX_RATE_MSB:`TX_RATE_LSB];                  // [RULE1]
    // Receive rate copies transmit unless the protocol allows a split
    rxr_d = rates_may_differ ? rate_reg[`RX_RATE_MSB:`RX_RATE_LSB]
                             : txr_d;                              // [RULE2]
    // Pulse width follows the transmit rate
    pw_d  = plen_map(txr_d, typea_reg[`A_PLEN_MSB:`A_PLEN_LSB]);   // [RULE9] [RULE10]
    // Guard codes above 6 saturate at 6
    egt_d = (typeb_reg[`B_EGT_MSB:`B_EGT_LSB] > `EGT_MAX) ? `EGT_MAX
            : typeb_reg[`B_EGT_MSB:`B_EGT_LSB];                    // [RULE12]
    // Each length bit adds one unit to the short figure
    sofl_d = `SOF_LOW_SHORT + 4'(typeb_reg[`B_SOF_LOW]);           // [RULE13]
    sofh_d = `SOF_HIGH_SHORT + 4'(typeb_reg[`B_SOF_HIGH]);         // [RULE14]
    eofl_d = `EOF_LOW_SHORT + 4'(typeb_reg[`B_EOF_LOW]);           // [RULE15]
    // Mid-spec overrides all three length bits; receive omission overrides the two SOF bits only
    if (typeb_reg[`B_MID]) begin
      sofl_d = `SOF_LOW_SHORT;  // [RULE16]
      sofh_d = `SOF_HIGH_SHORT;
      eofl_d = `EOF_LOW_SHORT;
    end
    if (typeb_reg[`B_OMIT]) begin
      sofl_d = `SOF_LOW_SHORT;  // [RULE17]
      sofh_d = `SOF_HIGH_SHORT;
    end
  end

  // Load new settings only while idle or at a frame start
  assign upd = frame_start || !active_frame_reg; // [RULE19]

  // Snapshot registers: a running frame keeps the settings it started with
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_frame_reg <= 1'b0;
      wsb_reg          <= `WRAP_START_BYTE;
      tx_rate_reg <= 4'h0;
      rx_rate_reg <= 4'h0;
      txrx_reg    <= 1'b0;
      ntp_reg     <= 1'b0;
      nrp_reg     <= 1'b0;
      wrap_reg    <= 1'b0;
      antcl_reg   <= 1'b0;
      omit_reg    <= 1'b0;
      eofreq_reg  <= 1'b0;
      pw_reg      <= 6'h00;
      pwv_reg     <= 1'b0;
      egt_reg     <= 3'h0;
      sofl_reg    <= 4'h0;
      sofh_reg    <= 4'h0;
      eofl_reg    <= 4'h0;
    end else begin
      active_frame_reg <= frame_active;
      wsb_reg          <= `WRAP_START_BYTE;                  // [RULE8]
      if (upd) begin
        tx_rate_reg <= txr_d;
        rx_rate_reg <= rxr_d;
        txrx_reg    <= rate_ok(txr_d) && rate_ok(rxr_d);  // [RULE3]
        ntp_reg     <= typea_reg[`A_NO_TX_PAR];           // [RULE6]
        nrp_reg     <= typea_reg[`A_NO_RX_PAR];           // [RULE7]
        wrap_reg    <= typea_reg[`A_WRAP];                // [RULE8]
        antcl_reg   <= typea_reg[`A_ANTCL];
        omit_reg    <= typeb_reg[`B_OMIT];                // [RULE17]
        eofreq_reg  <= !typeb_reg[`B_OMIT];               // [RULE17]
        pw_reg      <= pw_d[5:0];
        pwv_reg     <= pw_d[6];
        egt_reg     <= egt_d;
        sofl_reg    <= sofl_d;
        sofh_reg    <= sofh_d;
        eofl_reg    <= eofl_d;
      end
    end
  end

  // Outputs straight from snapshot flops
  assign tx_rate                = tx_rate_reg;
  assign rx_rate                = rx_rate_reg;
  assign txrx_enable            = txrx_reg;
  assign tx_parity_suppress     = ntp_reg;
  assign rx_parity_suppress     = nrp_reg;
  assign transport_frame_wrap   = wrap_reg;
  assign wrap_start_byte        = wsb_reg; // [RULE8]
  assign pulse_width            = pw_reg;
  assign pulse_width_valid      = pwv_reg;
  assign anticoll_frame         = antcl_reg;
  assign guard_etu              = egt_reg;
  assign sof_low_etu            = sofl_reg;
  assign sof_high_etu           = sofh_reg;
  assign eof_low_etu            = eofl_reg;
  assign eof_required           = eofreq_reg;
  assign receive_startstop_omit = omit_reg;

endmodule
`default_nettype wire

// ===== nfc_framing_config_regs_checker.sv
`default_nettype none
// ==========================================
// Checker on the decoded configuration outputs
module nfc_framing_config_regs_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       restore_defaults_cmd,
  input wire logic       frame_active,
  input wire logic       rates_may_differ,
  input wire logic [3:0] tx_rate,
  input wire logic [3:0] rx_rate,
  input wire logic       txrx_enable,
  input wire logic [7:0] wrap_start_byte,
  input wire logic [2:0] guard_etu,
  input wire logic [3:0] sof_low_etu,
  input wire logic [3:0] sof_high_etu,
  input wire logic       eof_required,
  input wire logic       receive_startstop_omit
);
  logic up;
  // Masks the first edge after reset release, before outputs settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up <= 1'b0;
    else up <= 1'b1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !up);
  AST_TXEN: assert property (txrx_enable == (tx_rate <= 4'h3 && rx_rate <= 4'h3))
    else $error("enable does not match rate codes");
  AST_RXCOPY: assert property (!frame_active ##1 !rates_may_differ
    |=> rx_rate == tx_rate) else $error("rx rate not copied");
  AST_RESTORE: assert property (restore_defaults_cmd && !frame_active ##1 !frame_active
    |=> tx_rate == 4'h0 && guard_etu == 3'h0) else $error("restore did not clear");
  AST_WRAP: assert property (wrap_start_byte == 8'hF0)
    else $error("bad start byte");
  AST_GUARD: assert property (guard_etu <= 3'h6)
    else $error("guard time too long");
  AST_SOFL: assert property (sof_low_etu == 4'hA || sof_low_etu == 4'hB)
    else $error("bad sof low");
  AST_SOFH: assert property (sof_high_etu == 4'h2 || sof_high_etu == 4'h3)
    else $error("bad sof high");
  AST_EOFREQ: assert property ((eof_required == !receive_startstop_omit) &&
    (!receive_startstop_omit || (sof_low_etu == 4'hA && sof_high_etu == 4'h2)))
    else $error("omit framing wrong");
  cover property (restore_defaults_cmd);
  cover property (!txrx_enable);
  cover property (receive_startstop_omit);
endmodule
bind nfc_framing_config_regs nfc_framing_config_regs_checker chk_i (.pclk, .presetn,
  .restore_defaults_cmd, .frame_active, .rates_may_differ, .tx_rate, .rx_rate,
  .txrx_enable, .wrap_start_byte, .guard_etu, .sof_low_etu, .sof_high_etu,
  .eof_required, .receive_startstop_omit);
`default_nettype wire

// ===== nfc_framing_config_regs_tb.sv
`include "nfc_framing_cfg.svh"
`default_nettype none
module nfc_framing_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_cmd, peer_cmd, rmd;
  logic fstart, fact, txen, txp, rxp, wrap, pwv, acol, eofr, omit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, tx_rate, rx_rate, sofl, sofh, eofl;
  logic [5:0]  pw;
  logic [2:0]  guard;
  logic [7:0]  wsb;
  logic        rerr;
  int          err_total, total_checks, cyc;
  logic [15:0] pt [7] = '{16'h072A, 16'h081B, 16'h1416, 16'h1614, 16'h2009, 16'h3D02, 16'h34FF};
  nfc_framing_config_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .restore_defaults_cmd(rst_cmd),
    .enter_standard_peer_cmd(peer_cmd), .rates_may_differ(rmd), .frame_start(fstart),
    .frame_active(fact), .tx_rate, .rx_rate, .txrx_enable(txen), .tx_parity_suppress(txp),
    .rx_parity_suppress(rxp), .transport_frame_wrap(wrap), .wrap_start_byte(wsb),
    .pulse_width(pw), .pulse_width_valid(pwv), .anticoll_frame(acol), .guard_etu(guard),
    .sof_low_etu(sofl), .sof_high_etu(sofh), .eof_low_etu(eofl), .eof_required(eofr),
    .receive_startstop_omit(omit));
  // ==========================================
  // Clock, timeout and reporting
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // ==========================================
  // APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic wt();
    repeat (3) @(posedge pclk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_cmd, peer_cmd, rmd, fstart, fact} = '0;
    pstrb = 4'hF;
    presetn = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wt();
    rd(`ADDR_RATE, 0);
    rd(`ADDR_TYPEA, 0);
    rd(`ADDR_TYPEB, 0);
    chk({txen, sofl, sofh, eofl, pw, eofr}, {1'b1, 4'hA, 4'h2, 4'hA, 6'h23, 1'b1});
    rd(`ADDR_STATUS, 32'h00000001);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, `ADDR_RATE, {c[3:0], c[3:0]});
      wt();
      chk(tx_rate, c);
      chk(txen, c < 4);
    end
    rmd <= 1'b1;
    apb(1'b1, `ADDR_RATE, 8'h12);
    wt();
    chk(rx_rate, 4'h2);
    apb(1'b1, `ADDR_RATE, 8'h15);
    wt();
    chk(txen, 1'b0);
    rmd <= 1'b0;
    foreach (pt[i]) begin
      apb(1'b1, `ADDR_RATE, {pt[i][15:12], pt[i][15:12]});
      apb(1'b1, `ADDR_TYPEA, {pt[i][11:8], 1'b0});
      wt();
      if (pt[i][7:0] == 8'hFF) chk(pwv, 1'b0);
      else chk({pwv, pw}, {1'b1, pt[i][5:0]});
    end
    apb(1'b1, `ADDR_TYPEA, 8'hE1);
    wt();
    chk({txp, rxp, wrap, acol}, 4'hF);
    chk(wsb, `WRAP_START_BYTE);
    rd(`ADDR_TYPEA, 8'hE1);
    apb(1'b1, `ADDR_TYPEB, 8'hFC);
    wt();
    chk({guard,sofl,sofh,eofl}, {3'h6,4'hB,4'h3,4'hB});
    apb(1'b1, `ADDR_TYPEB, 8'h1E);
    wt();
    chk({sofl, sofh, eofl}, {4'hA, 4'h2, 4'hA});
    apb(1'b1, `ADDR_TYPEB, 8'h1D);
    wt();
    chk({eofr, omit, sofl, sofh}, {2'b01, 4'hA, 4'h2});
    chk(eofl, 4'hB);
    apb(1'b0, 12'h100, 32'h0);
    chk({rerr, rdat}, {1'b1, 32'h0});
    pstrb <= 4'hE;
    apb(1'b1, `ADDR_TYPEB, 8'hAA);
    pstrb <= 4'hF;
    rd(`ADDR_TYPEB, 8'h1D);
    rst_cmd <= 1'b1;
    @(posedge pclk);
    rst_cmd <= 1'b0;
    rd(`ADDR_RATE, 0);
    rd(`ADDR_TYPEA, 0);
    rd(`ADDR_TYPEB, 0);
    apb(1'b1, `ADDR_RATE, 8'h33);
    peer_cmd <= 1'b1;
    @(posedge pclk);
    peer_cmd <= 1'b0;
    rd(`ADDR_RATE, `PEER_RATE_DEFAULT);
    wt();
    fact <= 1'b1;
    apb(1'b1, `ADDR_RATE, 8'h22);
    wt();
    chk(tx_rate, 4'h0);
    rd(`ADDR_STATUS, 32'h00000003);
    fstart <= 1'b1;
    @(posedge pclk);
    fstart <= 1'b0;
    wt();
    chk(tx_rate, 4'h2);
    apb(1'b1, `ADDR_RATE, 8'h11);
    wt();
    chk(tx_rate, 4'h2);
    fact <= 1'b0;
    wt();
    chk(tx_rate, 4'h1);
    summarize();
  end
endmodule
`default_nettype wire

// ===== nfc_framing_pkg.sv
`default_nettype none
package nfc_framing_pkg;
  // Bit rate codes
  typedef enum logic [3:0] {
    RATE_FC128 = 4'h0,
    RATE_FC64  = 4'h1,
    RATE_FC32  = 4'h2,
    RATE_FC16  = 4'h3
  } rate_code_t;
endpackage
`default_nettype wire
